// [host_bus_wait_and_strobe.sv]
// wait-state insertion and address strobe handling of the host bus port
// assumes pins synchronous to ref_clk_i and mode inputs held steady per cycle
`timescale 1ns/1ps

module host_bus_wait_and_strobe (
  // clock, reset, enable
  input  wire logic                             ref_clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             clk_en_i,
  // mode selection
  input  wire logic [1:0]                       cpu_mode_i,
  input  wire host_bus_pkg::op_mode_t           op_mode_i,
  // dma master cycle request and completion
  input  wire host_bus_pkg::mst_req_t           mst_req_i,
  output logic                                  mst_ready_o,
  output logic                                  mst_done_o,
  // address bus
  output logic [host_bus_pkg::ADDR_W-1:0]       addr_o,
  output logic                                  addr_oe_o,
  output logic                                  addr0_oe_o,
  // wait pin
  input  wire logic                             wait_i,
  output logic                                  wait_o,
  output logic                                  wait_oe_o,
  // address strobe pin, active low
  input  wire logic                             address_valid_strobe_n_i,
  output logic                                  address_valid_strobe_n_o,
  output logic                                  address_valid_strobe_n_oe_o,
  // slave register access
  input  wire logic                             chip_sel_n_i,
  input  wire logic [host_bus_pkg::REGSEL_W-1:0] register_select_lines_i,
  input  wire logic                             slv_ready_i,
  output logic                                  slv_start_o,
  output logic [host_bus_pkg::REGSEL_W-1:0]     slv_reg_sel_o
);

  host_bus_pkg::state_t s_q;
  host_bus_pkg::state_t s_d;
  logic                 is_master;
  logic                 is_slave;
  logic                 cpu_wide;
  logic                 wait_seen;
  logic                 slv_qual;

  // mode decode
  assign is_master = (op_mode_i == host_bus_pkg::OP_MASTER);
  assign is_slave  = (op_mode_i == host_bus_pkg::OP_SLAVE);
  assign cpu_wide  = (cpu_mode_i < host_bus_pkg::CPU_MODE2);

  // wait level that decides the end of the second or wait state
  always_comb begin
    if (cpu_mode_i == host_bus_pkg::CPU_MODE0) begin
      wait_seen = s_q.wait_smp;
    end else begin
      wait_seen = wait_i; // falling-half sample
    end
  end

  // slave access qualification by chip select and strobe
  always_comb begin
    if (cpu_wide) begin
      slv_qual = !chip_sel_n_i; // strobe ignored
    end else begin
      slv_qual = !chip_sel_n_i && !address_valid_strobe_n_i;
    end
  end

  // next state
  always_comb begin
    s_d           = s_q;
    s_d.done      = 1'h0;
    s_d.slv_start = 1'h0;
    // master bus cycle sequencer
    if (!is_master) begin
      s_d.st = host_bus_pkg::BUS_IDLE;
      s_d.ph = host_bus_pkg::PH_RISE;
    end else if (s_q.st == host_bus_pkg::BUS_IDLE) begin
      s_d.ph = host_bus_pkg::PH_RISE;
      if (mst_req_i.req) begin
        s_d.st   = host_bus_pkg::FIRST_BUS_STATE;
        s_d.addr = mst_req_i.addr;
      end
    end else begin
      s_d.ph = ~s_q.ph;
      // rising-half sample for cpu mode 0
      if (s_q.ph == host_bus_pkg::PH_RISE) begin
        s_d.wait_smp = wait_i;
      end
      if (s_q.ph == host_bus_pkg::PH_FALL) begin
        case (s_q.st)
          host_bus_pkg::FIRST_BUS_STATE: begin
            s_d.st = host_bus_pkg::SECOND_BUS_STATE;
          end
          host_bus_pkg::SECOND_BUS_STATE,
          host_bus_pkg::INSERTED_WAIT_STATE: begin
            if (wait_seen) begin
              s_d.st = host_bus_pkg::INSERTED_WAIT_STATE;
            end else begin
              s_d.st = host_bus_pkg::THIRD_BUS_STATE;
            end
          end
          host_bus_pkg::THIRD_BUS_STATE: begin
            s_d.st   = host_bus_pkg::BUS_IDLE;
            s_d.done = 1'h1;
          end
          default: begin
            s_d.st = host_bus_pkg::BUS_IDLE;
          end
        endcase
      end
    end
    // slave access tracking and wait request
    if (!is_slave || chip_sel_n_i) begin
      s_d.slv_active = 1'h0;
    end else if (!s_q.slv_active && slv_qual) begin
      s_d.slv_active = 1'h1;
      s_d.slv_start  = 1'h1;
      s_d.reg_sel    = register_select_lines_i;
    end
    if (is_slave) begin
      s_d.wait_out = slv_qual && !slv_ready_i;
    end else begin
      s_d.wait_out = host_bus_pkg::WAIT_RST;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q            <= '0;
      s_q.st         <= host_bus_pkg::BUS_IDLE;
      s_q.ph         <= host_bus_pkg::PH_RISE;
      s_q.wait_out   <= host_bus_pkg::WAIT_RST;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // pin drivers
  assign wait_o      = s_q.wait_out;
  assign wait_oe_o   = !is_master;
  assign addr_o      = s_q.addr;
  assign addr_oe_o   = is_master && (s_q.st != host_bus_pkg::BUS_IDLE);
  assign addr0_oe_o  = addr_oe_o && cpu_wide;
  assign address_valid_strobe_n_oe_o = is_master; // input otherwise
  assign address_valid_strobe_n_o =
    (s_q.st == host_bus_pkg::SECOND_BUS_STATE ||
     s_q.st == host_bus_pkg::INSERTED_WAIT_STATE ||
     s_q.st == host_bus_pkg::THIRD_BUS_STATE) ?
    host_bus_pkg::STRB_ON : host_bus_pkg::STRB_OFF;

  // user side handshake
  assign mst_ready_o   = is_master && (s_q.st == host_bus_pkg::BUS_IDLE);
  assign mst_done_o    = s_q.done;
  assign slv_start_o   = s_q.slv_start;
  assign slv_reg_sel_o = s_q.reg_sel;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic m0_fall;
  logic mx_fall;
  logic in_t2;
  logic in_tw;
  assign in_t2 = s_q.st == host_bus_pkg::SECOND_BUS_STATE;
  assign in_tw = s_q.st == host_bus_pkg::INSERTED_WAIT_STATE;
  assign m0_fall = clk_en_i && is_master && s_q.ph == host_bus_pkg::PH_FALL
                   && cpu_mode_i == host_bus_pkg::CPU_MODE0;
  assign mx_fall = clk_en_i && is_master && s_q.ph == host_bus_pkg::PH_FALL
                   && cpu_mode_i != host_bus_pkg::CPU_MODE0;

  a_m0_t2_insert: assert property (m0_fall && in_t2 && s_q.wait_smp
    |=> in_tw) else $error("mode 0 wait not inserted after second state");
  a_m0_tw_repeat: assert property (m0_fall && in_tw && s_q.wait_smp
    |=> in_tw) else $error("mode 0 extra wait state missing");
  a_m0_proceed: assert property (m0_fall && (in_t2 || in_tw)
    && !s_q.wait_smp |=> s_q.st == host_bus_pkg::THIRD_BUS_STATE)
    else $error("mode 0 did not proceed to third state");
  a_mx_t2_insert: assert property (mx_fall && in_t2 && wait_i
    |=> in_tw) else $error("falling edge wait not inserted");
  a_mx_tw_repeat: assert property (mx_fall && in_tw && wait_i
    |=> in_tw ##1 in_tw) else $error("falling edge extra wait missing");
  a_mx_proceed: assert property (mx_fall && (in_t2 || in_tw) && !wait_i
    |=> s_q.st == host_bus_pkg::THIRD_BUS_STATE)
    else $error("falling edge did not proceed to third state");
  a_slave_wait_hold: assert property (clk_en_i && is_slave && slv_qual
    && !slv_ready_i |=> wait_o && wait_oe_o)
    else $error("slave wait not driven high");
  a_strobe_wide: assert property (is_master && cpu_wide && in_t2
    |-> !address_valid_strobe_n_o && address_valid_strobe_n_oe_o && addr0_oe_o)
    else $error("strobe or full address not driven");
  a_strobe_narrow: assert property (is_master && !cpu_wide
    && (in_t2 || in_tw) |-> !address_valid_strobe_n_o && addr_oe_o
    && !addr0_oe_o) else $error("strobe or upper address not driven");
  a_slave_ignore: assert property (clk_en_i && is_slave && cpu_wide
    && !chip_sel_n_i && !s_q.slv_active |=> slv_start_o)
    else $error("slave access not taken regardless of strobe");
  a_slave_qualify: assert property (clk_en_i && is_slave && !cpu_wide
    && address_valid_strobe_n_i |=> !slv_start_o)
    else $error("select taken without strobe");
  a_idle_modes: assert property (clk_en_i && !is_master && !is_slave
    |-> (wait_oe_o && !address_valid_strobe_n_oe_o) ##1 wait_o)
    else $error("reset or stop pin drive wrong");

  c_wait_cycle: cover property (in_t2 ##[1:4] in_tw ##[1:8]
    s_q.st == host_bus_pkg::THIRD_BUS_STATE);
  c_master_done: cover property (mst_done_o);
  c_slave_wait: cover property (slv_start_o ##1 wait_o ##[1:8] !wait_o);

endmodule

// [host_bus_pkg.sv]
// shared types and constants for the host bus wait and strobe block
// assumes a single ref_clk_i domain, each bus state two clock cycles long
package host_bus_pkg;

  // widths
  localparam int ADDR_W   = 24;
  localparam int REGSEL_W = 7;

  // cpu interface modes
  localparam logic [1:0] CPU_MODE0 = 2'h0;
  localparam logic [1:0] CPU_MODE2 = 2'h2;

  // bus state phases: rising half, falling half
  localparam logic PH_RISE = 1'h0;
  localparam logic PH_FALL = 1'h1;

  // reset and active values of pin drivers
  localparam logic WAIT_RST = 1'h1;
  localparam logic STRB_OFF = 1'h1;
  localparam logic STRB_ON  = 1'h0;

  // operating mode of the chip
  typedef enum logic [1:0] {
    OP_RESET,
    OP_MASTER,
    OP_SLAVE,
    OP_STOP
  } op_mode_t;

  // master bus cycle states
  typedef enum logic [2:0] {
    BUS_IDLE,
    FIRST_BUS_STATE,
    SECOND_BUS_STATE,
    INSERTED_WAIT_STATE,
    THIRD_BUS_STATE
  } bus_state_t;

  // master cycle request from the dma side
  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
  } mst_req_t;

  // all state of the block
  typedef struct packed {
    bus_state_t          st;
    logic                ph;
    logic                wait_smp;
    logic [ADDR_W-1:0]   addr;
    logic                done;
    logic                slv_active;
    logic                slv_start;
    logic [REGSEL_W-1:0] reg_sel;
    logic                wait_out;
  } state_t;

endpackage

// [host_bus_model.sv]
// host side of the shared bus: stretches device master cycles with wait
// assumes the bench resolves the strobe pin level and feeds it in here
`timescale 1ns/1ps

module host_bus_model (
  // clock
  input  wire logic       ref_clk_i,
  // strobe pin level as seen on the bus
  input  wire logic       strobe_n_i,
  // cycles that wait stays high once the strobe falls
  input  wire logic [3:0] hold_i,
  // wait drive towards the device
  output logic            wait_o
);
  logic [3:0] cnt_q;

  // slow host: wait high for hold_i cycles of each strobe-low period
  initial begin
    wait_o = 1'h0;
    cnt_q  = 4'h0;
    forever begin
      @(posedge ref_clk_i);
      #1;
      if (!strobe_n_i) begin
        wait_o = (cnt_q < hold_i);
        cnt_q  = cnt_q + 4'h1;
      end else begin
        wait_o = ~wait_o; // released: wait inverts every cycle while the strobe is high
        cnt_q  = 4'h0;
      end
    end
  end
endmodule

// [host_bus_wait_and_strobe_test.sv]
// self-checking bench for the host bus wait and strobe block
// assumes host_bus_pkg and host_bus_model are compiled first
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  $display("ERROR %s exp %0h got %0h", nm, exp, got); \
  num_errors++; end end

module host_bus_wait_and_strobe_test;
  logic                   ref_clk_i, rst_i, cs_n, slv_ready, host_strb_n;
  logic [1:0]             cpu_mode;
  host_bus_pkg::op_mode_t op_mode;
  host_bus_pkg::mst_req_t req;
  logic                   mst_ready, mst_done, addr_oe, addr0_oe, slv_start;
  logic                   wait_o, wait_oe, strb_o, strb_oe, host_wait;
  logic                   wait_w, strb_w, clk_en;
  logic [23:0]            addr;
  logic [6:0]             reg_sel, rsel;
  logic [3:0]             hold;
  int                     num_errors, n_checks;

  // resolved pin levels: device drives when enabled
  assign wait_w = wait_oe ? wait_o : host_wait;
  assign strb_w = strb_oe ? strb_o : host_strb_n;

  host_bus_wait_and_strobe u_host_bus_wait_and_strobe (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .cpu_mode_i(cpu_mode), .op_mode_i(op_mode), .mst_req_i(req),
    .mst_ready_o(mst_ready), .mst_done_o(mst_done), .addr_o(addr),
    .addr_oe_o(addr_oe), .addr0_oe_o(addr0_oe), .wait_i(wait_w),
    .wait_o(wait_o), .wait_oe_o(wait_oe), .address_valid_strobe_n_i(strb_w),
    .address_valid_strobe_n_o(strb_o), .address_valid_strobe_n_oe_o(strb_oe),
    .chip_sel_n_i(cs_n), .register_select_lines_i(rsel),
    .slv_ready_i(slv_ready), .slv_start_o(slv_start),
    .slv_reg_sel_o(reg_sel));

  host_bus_model u_host_bus_model (
    .ref_clk_i(ref_clk_i), .strobe_n_i(strb_w), .hold_i(hold),
    .wait_o(host_wait));

  // verdict and end of run
  task automatic test_done;
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // advance n cycles, landing just after the edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask

  // one master cycle; strobe-low length shows the wait states inserted
  task automatic master_cycle(input logic [1:0] m, input logic [3:0] h);
    int cnt, lows, w;
    cpu_mode = m;
    op_mode  = host_bus_pkg::OP_MASTER;
    hold     = h;
    tick(1);
    `CHK("ready", 1'h1, mst_ready)
    req.req  = 1'h1;
    req.addr = {m, h, 18'h2A5C3};
    tick(1);
    req.req  = 1'h0;
    w = (m == 2'h0) ? (h + 1) / 2 : h / 2;
    cnt  = 0;
    lows = 0;
    while (mst_done !== 1'h1 && cnt < 40) begin
      tick(1);
      cnt++;
      if (strb_w === 1'h0) lows++;
      if (lows == 1 && strb_w === 1'h0) begin
        `CHK("addr", {m, h, 18'h2A5C3}, addr)
        `CHK("addr0_oe", (m < 2'h2), addr0_oe)
        `CHK("strb_oe", 1'h1, strb_oe)
        `CHK("addr_oe", 1'h1, addr_oe)
      end
    end
    if (cnt == 40) begin
      num_errors++;
      test_done();
    end
    `CHK("strobe low cycles", 4 + 2 * w, lows)
    `CHK("done cycles", 6 + 2 * w, cnt)
    `CHK("addr_oe end", 1'h0, addr_oe)
  endtask

  // clock enable low holds the cycle in its second state
  task automatic frozen_cycle;
    int cnt;
    cpu_mode = 2'h0;
    op_mode  = host_bus_pkg::OP_MASTER;
    hold     = 4'h0;
    tick(1);
    req.req  = 1'h1;
    req.addr = 24'h0F1E2D;
    tick(1);
    req.req  = 1'h0;
    tick(2);
    clk_en   = 1'h0;
    tick(5);
    `CHK("frozen strobe", 1'h0, strb_w)
    `CHK("frozen done", 1'h0, mst_done)
    clk_en   = 1'h1;
    cnt      = 0;
    while (mst_done !== 1'h1 && cnt < 40) begin
      tick(1);
      cnt++;
    end
    if (cnt == 40) begin
      num_errors++;
      test_done();
    end
    `CHK("resume cycles", 4, cnt)
    `CHK("frozen addr", 24'h0F1E2D, addr)
  endtask

  // slave access; strobe qualifies the select lines in cpu modes 2 and 3 only
  task automatic slave_access(input logic [1:0] m, input logic strb);
    logic acc;
    acc = (m < 2'h2) || !strb;
    cpu_mode    = m;
    op_mode     = host_bus_pkg::OP_SLAVE;
    slv_ready   = 1'h0;
    rsel        = 7'h55 ^ {5'h0, m};
    tick(2);
    `CHK("strb_oe", 1'h0, strb_oe)
    `CHK("wait_oe", 1'h1, wait_oe)
    cs_n        = 1'h0;
    host_strb_n = strb;
    tick(1);
    `CHK("start", acc, slv_start)
    host_strb_n = 1'h0;
    tick(1);
    if (!acc) `CHK("late start", 1'h1, slv_start)
    `CHK("reg_sel", rsel, reg_sel)
    tick(1);
    `CHK("wait held", 1'h1, wait_w)
    slv_ready = 1'h1;
    tick(2);
    `CHK("wait off", 1'h0, wait_w)
    cs_n        = 1'h1;
    host_strb_n = 1'h1;
    tick(1);
  endtask

  // reset and stop modes: wait driven high, strobe is an input
  task automatic idle_mode(input host_bus_pkg::op_mode_t m);
    op_mode = m;
    tick(2);
    `CHK("idle wait_oe", 1'h1, wait_oe)
    `CHK("idle wait", 1'h1, wait_w)
    `CHK("idle strb_oe", 1'h0, strb_oe)
  endtask

  // 10 MHz clock
  initial begin
    ref_clk_i = 1'h0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // main sequence
  initial begin
    num_errors = 0;
    n_checks = 0;
    rst_i = 1'h1;
    clk_en = 1'h1;
    cpu_mode = 2'h0;
    op_mode = host_bus_pkg::OP_RESET;
    req = '0;
    cs_n = 1'h1;
    slv_ready = 1'h1;
    host_strb_n = 1'h1;
    rsel = 7'h00;
    hold = 4'h0;
    tick(10);
    rst_i = 1'h0;
    for (int m = 0; m < 4; m++) begin
      master_cycle(m[1:0], 4'h0);
      master_cycle(m[1:0], 4'h1);
      master_cycle(m[1:0], 4'h4);
      slave_access(m[1:0], 1'h1);
      idle_mode(m[0] ? host_bus_pkg::OP_STOP : host_bus_pkg::OP_RESET);
    end
    frozen_cycle();
    test_done();
  end
endmodule
